// ### hw/cpm_chan_check.sv
`timescale 1ns/1ps
module cpm_chan_check import cpm_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // one channel's result, thresholds and flag
  cpm_chk_if.chk ch
);
  logic [3:0] run_reg;
  logic flag_reg;
  logic out_range;
  logic [3:0] need;
  logic [3:0] run_next;

  // low threshold first; a low above the high hides the high
  always_comb
  begin
    out_range = ch.result < ch.lo;
    if (ch.lo <= ch.hi && ch.result > ch.hi)
      out_range = 1'b1;
    need = (ch.pers == 4'h0) ? 4'h1 : ch.pers;
    run_next = (run_reg == 4'hf) ? run_reg : run_reg + 4'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_reg <= 4'h0;
    else if (ch.strobe)
      run_reg <= out_range ? run_next : 4'h0;
    else if (ch.clr)
      run_reg <= 4'h0;
  end

  // flag sticks until cleared; a new hit beats the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_reg <= 1'b0;
    else if (ch.strobe && out_range && run_next >= need)
      flag_reg <= 1'b1;
    else if (ch.clr)
      flag_reg <= 1'b0;
  end

  assign ch.flag = flag_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_flag_holds: assert property (ch.flag && !ch.clr |=> ch.flag)
    else $error("interrupt flag dropped without clear");
  a_flag_cause: assert property ($rose(ch.flag) |-> $past(ch.strobe)
    && $past(out_range) && ($past(run_next) >= $past(need)))
    else $error("flag set before persistence reached");
  a_clear_restart: assert property (ch.clr && !ch.strobe |=> !ch.flag && run_reg == 4'h0)
    else $error("clear did not drop flag and count");
  a_inrange_reset: assert property (ch.strobe && !out_range |=> run_reg == 4'h0)
    else $error("in-range result kept the count");
  c_flag_raised: cover property ($rose(ch.flag));
endmodule : cpm_chan_check

// ### hw/cpm_chk_if.sv
`timescale 1ns/1ps
interface cpm_chk_if;
  logic [15:0] result;
  logic strobe;
  logic [15:0] lo;
  logic [15:0] hi;
  logic [3:0] pers;
  logic clr;
  logic flag;
  modport seq (output result, strobe, lo, hi, pers, clr, input flag);
  modport chk (input result, strobe, lo, hi, pers, clr, output flag);
endinterface : cpm_chk_if

// ### hw/cpm_pkg.sv
package cpm_pkg;
  // register byte offsets, one aligned word each
  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_COLOR_TIME = 8'h04;
  localparam logic [7:0] OFS_PROX_TIME = 8'h08;
  localparam logic [7:0] OFS_WAIT_TIME = 8'h0c;
  localparam logic [7:0] OFS_CONFIG = 8'h10;
  localparam logic [7:0] OFS_CTHR = 8'h14;
  localparam logic [7:0] OFS_PTHR = 8'h18;
  localparam logic [7:0] OFS_PERS = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_CDATA0 = 8'h24;
  localparam logic [7:0] OFS_CDATA1 = 8'h28;
  localparam logic [7:0] OFS_PROX_DATA = 8'h2c;
  // enable register bit positions
  localparam int EN_POWER = 0;
  localparam int EN_COLOR = 1;
  localparam int EN_PROX = 2;
  localparam int EN_WEN = 3;
  localparam int EN_CIEN = 4;
  localparam int EN_PIEN = 5;
  // status bit positions; writing one to a flag bit clears it
  localparam int ST_CVALID = 0;
  localparam int ST_PROX_VALID = 1;
  localparam int ST_CINT = 4;
  localparam int ST_PINT = 5;
  // config register field positions
  localparam int CFG_LONG = 0;
  localparam int CFG_DRV_LO = 2;
  localparam int CFG_PULSES_LO = 8;
  // values after reset
  localparam logic [5:0] ENABLE_RST = 6'h00;
  localparam logic [7:0] TIME_RST = 8'hff;
  localparam logic [7:0] PROX_PULSE_COUNT_RST = 8'h01;
  localparam logic [1:0] DRIVE_RST = 2'h0;
  localparam logic [15:0] THR_LO_RST = 16'h0000;
  localparam logic [15:0] THR_HI_RST = 16'hffff;
  // timing
  localparam real CLK_MHZ = 10.0;
  localparam real STEP_TIME_MS = 2.4;
  localparam real LED_ON_US = 6.3;
  localparam real LED_PERIOD_US = 14.0;
  localparam int STEP_CYC_DEF = int'(STEP_TIME_MS * 1000.0 * CLK_MHZ);
  localparam int LED_ON_CYC = int'(LED_ON_US * CLK_MHZ);
  localparam int LED_PER_CYC = int'(LED_PERIOD_US * CLK_MHZ);
  localparam logic [8:0] STEP_BASE = 9'h100;
  localparam int LONG_WAIT_MULT = 12;

  typedef enum logic [2:0] {
    ST_SLEEP, ST_START, ST_PROX_ACCUM, ST_PROX_WAIT, ST_PROX_ADC,
    ST_WAIT, ST_COLOR_INIT, ST_COLOR_ADC
  } cpm_state_e;
endpackage : cpm_pkg

// ### hw/cpm_sequencer.sv
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
// Notes on behaviour
// - after reset the sequencer sleeps and measures nothing until powered on.
// - power-on goes to start, then runs enabled proximity, wait, colour phases.
// - power-on bit is bit zero of the enable register at offset zero.
// - on power-off, conversions under way finish before sleep.
// - four colour channels integrate together and move to data at once.
// - results reach readable registers whole, never half updated.
// - after colour transfer the sequencer moves on by itself.
// - timed phases last 2.4 ms times 256 minus register value.
// - LED output on 6.3 us in every 14.0 us during accumulate.
// - emit the programmed 1 to 255 LED pulses per proximity cycle.
// - drive-strength field selects one of four sink currents.
// - add signal while LED on, subtract background while off.
// - after last pulse give 16-bit result in two bytes.
// - proximity conversion 1 to 256 steps of 2.4 ms scales result.
// - proximity valid set after first cycle, kept until proximity disabled.
// - interrupt pin is a level, not a pulse.
// - enabled interrupt when clear or proximity result leaves its window.
// - interrupt stays until the host clears it.
// - persistence needs that many consecutive out-of-range results.
// - clear and proximity keep separate thresholds and persistence.
// - host bus accepts any request pace.
// - proximity wait lasts fixed 2.4 ms between accumulate and conversion.
// - long-wait multiplies wait time by twelve.
// - colour init lasts 2.4 ms before colour conversion.
// - proximity interrupt appears at end of proximity conversion.
module cpm_sequencer import cpm_pkg::*; #(
  parameter int STEP_CYC = STEP_CYC_DEF,
  parameter int LVL_W = 10
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // photodiode levels from the analog front end
  input wire logic [LVL_W-1:0] red_level,
  input wire logic [LVL_W-1:0] green_level,
  input wire logic [LVL_W-1:0] blue_level,
  input wire logic [LVL_W-1:0] clear_level,
  input wire logic [LVL_W-1:0] prox_level,
  // led and interrupt pins
  output logic led_sink_output,
  output logic [1:0] led_drive_strength,
  output logic int_n
);
  localparam int SW = 5 * LVL_W;
  localparam int STEP_W = $clog2(STEP_CYC + 1);

  logic [SW-1:0] sens_meta_reg;
  logic [SW-1:0] sens_reg;
  logic [LVL_W-1:0] lvl [5];
  cpm_state_e state_reg;
  cpm_state_e state_next;
  logic [5:0] enable_reg;
  logic [7:0] color_integration_count;
  logic [7:0] prox_conversion_count;
  logic [7:0] wait_time_count;
  logic long_wait_select;
  logic [7:0] prox_pulse_count;
  logic [15:0] cthr_lo_reg, cthr_hi_reg, pthr_lo_reg, pthr_hi_reg;
  logic [3:0] cpers_reg, ppers_reg;
  logic [15:0] acc_reg [4];
  logic [15:0] acc_plus [4];
  logic [15:0] color_data_reg [4];
  logic [15:0] prox_result_regs;
  logic signed [19:0] prox_acc_reg;
  logic color_valid_reg, prox_result_valid;
  logic [STEP_W-1:0] step_cnt_reg;
  logic [11:0] steps_left_reg;
  logic [11:0] steps_load;
  logic step_end, phase_done;
  logic [7:0] pcyc_reg;
  logic [7:0] pulses_reg;
  logic [7:0] pulse_target;
  logic accum_done;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic wr_go;
  logic [15:0] prox_scaled;
  logic [28:0] prox_prod;
  logic [8:0] pconv_steps;
  logic power_on_bit, color_enable, proximity_enable, wen;
  cpm_chk_if cchk ();
  cpm_chk_if pchk ();

  // levels come from another domain: two flops before use
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sens_meta_reg <= '0;
      sens_reg <= '0;
    end
    else
    begin
      sens_meta_reg <= {prox_level, clear_level, blue_level, green_level, red_level};
      sens_reg <= sens_meta_reg;
    end
  end

  for (genvar i = 0; i < 5; i++)
  begin : g_lvl
    assign lvl[i] = sens_reg[i*LVL_W +: LVL_W];
  end

  assign power_on_bit = enable_reg[EN_POWER];
  assign color_enable = enable_reg[EN_COLOR];
  assign proximity_enable = enable_reg[EN_PROX];
  assign wen = enable_reg[EN_WEN];
  assign pulse_target = (prox_pulse_count == 8'h00) ? 8'h01 : prox_pulse_count;
  assign step_end = step_cnt_reg == STEP_W'(STEP_CYC - 1);
  assign phase_done = step_end && steps_left_reg == 12'h000;
  assign accum_done = pcyc_reg == 8'(LED_PER_CYC - 1) && pulses_reg == pulse_target - 8'h01;
  assign pconv_steps = STEP_BASE - {1'b0, prox_conversion_count};

  // phase order, skipping phases not enabled
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_SLEEP: if (power_on_bit) state_next = ST_START;
      ST_START:
        if (!power_on_bit) state_next = ST_SLEEP;
        else if (proximity_enable) state_next = ST_PROX_ACCUM;
        else if (wen) state_next = ST_WAIT;
        else if (color_enable) state_next = ST_COLOR_INIT;
      // an accumulate always runs through to its conversion
      ST_PROX_ACCUM: if (accum_done) state_next = ST_PROX_WAIT;
      ST_PROX_WAIT: if (phase_done) state_next = ST_PROX_ADC;
      ST_PROX_ADC:
        if (phase_done)
          state_next = !power_on_bit ? ST_SLEEP : wen ? ST_WAIT
            : color_enable ? ST_COLOR_INIT : ST_START;
      ST_WAIT:
        if (phase_done)
          state_next = !power_on_bit ? ST_SLEEP : color_enable ? ST_COLOR_INIT : ST_START;
      ST_COLOR_INIT: if (phase_done) state_next = ST_COLOR_ADC;
      // move on unaided after the colour transfer
      ST_COLOR_ADC: if (phase_done) state_next = power_on_bit ? ST_START : ST_SLEEP;
    endcase
  end

  // step count of the phase being entered, minus one
  always_comb
  begin
    unique case (state_next)
      ST_PROX_ADC: steps_load = 12'(pconv_steps - 9'h001);
      // long wait is twelve times longer
      ST_WAIT: steps_load = 12'((STEP_BASE - {1'b0, wait_time_count})
        * (long_wait_select ? LONG_WAIT_MULT : 1) - 1);
      ST_COLOR_ADC: steps_load = 12'(STEP_BASE - {1'b0, color_integration_count} - 9'h001);
      default: steps_load = 12'h000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= ST_SLEEP;
    else
      state_reg <= state_next;
  end

  // init and wait phases count whole 2.4 ms steps
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      step_cnt_reg <= '0;
      steps_left_reg <= 12'h000;
    end
    else if (state_next != state_reg)
    begin
      step_cnt_reg <= '0;
      steps_left_reg <= steps_load;
    end
    else if (step_end)
    begin
      step_cnt_reg <= '0;
      steps_left_reg <= steps_left_reg - 12'h001;
    end
    else
      step_cnt_reg <= step_cnt_reg + STEP_W'(1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pcyc_reg <= 8'h00;
      pulses_reg <= 8'h00;
    end
    else if (state_reg != ST_PROX_ACCUM)
    begin
      pcyc_reg <= 8'h00;
      pulses_reg <= 8'h00;
    end
    else if (pcyc_reg == 8'(LED_PER_CYC - 1))
    begin
      pcyc_reg <= 8'h00;
      pulses_reg <= pulses_reg + 8'h01;
    end
    else
      pcyc_reg <= pcyc_reg + 8'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      led_sink_output <= 1'b0;
    else
      led_sink_output <= state_reg == ST_PROX_ACCUM && pcyc_reg < 8'(LED_ON_CYC);
  end

  // on-time adds signal plus ambient, equal off-time removes ambient
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prox_acc_reg <= '0;
    else if (state_reg == ST_START)
      prox_acc_reg <= '0;
    else if (state_reg == ST_PROX_ACCUM && pcyc_reg < 8'(LED_ON_CYC))
      prox_acc_reg <= prox_acc_reg + 20'(lvl[4]);
    else if (state_reg == ST_PROX_ACCUM && pcyc_reg < 8'(2 * LED_ON_CYC))
      prox_acc_reg <= prox_acc_reg - 20'(lvl[4]);
  end

  // conversion length scales the result, saturated to 16 bits
  always_comb
  begin
    prox_prod = prox_acc_reg[19] ? 29'h0 : 29'(prox_acc_reg) * 29'(pconv_steps);
    prox_scaled = (prox_prod > 29'h000ffff) ? 16'hffff : prox_prod[15:0];
  end

  // all four channels integrate together, saturating
  for (genvar i = 0; i < 4; i++)
  begin : g_acc
    logic [16:0] sum;
    assign sum = {1'b0, acc_reg[i]} + 17'(lvl[i]);
    assign acc_plus[i] = sum[16] ? 16'hffff : sum[15:0];
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        acc_reg[i] <= 16'h0000;
      else if (state_reg == ST_COLOR_INIT)
        acc_reg[i] <= 16'h0000;
      else if (state_reg == ST_COLOR_ADC && step_end)
        acc_reg[i] <= acc_plus[i];
    end
    // data word is loaded in one edge, so reads see old or new
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        color_data_reg[i] <= 16'h0000;
      else if (state_reg == ST_COLOR_ADC && phase_done)
        color_data_reg[i] <= acc_plus[i];
    end
  end

  // 16-bit result, low byte and high byte in one word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prox_result_regs <= 16'h0000;
    else if (state_reg == ST_PROX_ADC && phase_done)
      prox_result_regs <= prox_scaled;
  end

  // valid after a completed cycle, dropped with the enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prox_result_valid <= 1'b0;
    else if (state_reg == ST_PROX_ADC && phase_done)
      prox_result_valid <= 1'b1;
    else if (!proximity_enable)
      prox_result_valid <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      color_valid_reg <= 1'b0;
    else if (state_reg == ST_COLOR_ADC && phase_done)
      color_valid_reg <= 1'b1;
    else if (!color_enable)
      color_valid_reg <= 1'b0;
  end

  // separate window and persistence per channel
  assign cchk.result = acc_plus[3];
  assign cchk.strobe = state_reg == ST_COLOR_ADC && phase_done;
  assign cchk.lo = cthr_lo_reg;
  assign cchk.hi = cthr_hi_reg;
  assign cchk.pers = cpers_reg;
  assign cchk.clr = wr_go && paddr == OFS_STATUS && pwdata[ST_CINT];
  assign pchk.result = prox_scaled;
  // proximity result judged at end of conversion
  assign pchk.strobe = state_reg == ST_PROX_ADC && phase_done;
  assign pchk.lo = pthr_lo_reg;
  assign pchk.hi = pthr_hi_reg;
  assign pchk.pers = ppers_reg;
  assign pchk.clr = wr_go && paddr == OFS_STATUS && pwdata[ST_PINT];

  cpm_chan_check u_clear_chk (.pclk(pclk), .presetn(presetn), .ch(cchk.chk));
  cpm_chan_check u_prox_chk (.pclk(pclk), .presetn(presetn), .ch(pchk.chk));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_n <= 1'b1;
    else
      int_n <= !((cchk.flag && enable_reg[EN_CIEN]) || (pchk.flag && enable_reg[EN_PIEN]));
  end

  // zero-wait-state answer whatever the spacing of requests
  assign wr_go = psel && penable && pready && pwrite;

  always_comb
  begin
    rd_hit = 1'b1;
    unique case (paddr)
      OFS_ENABLE: rd_mux = {26'h0, enable_reg};
      OFS_COLOR_TIME: rd_mux = {24'h0, color_integration_count};
      OFS_PROX_TIME: rd_mux = {24'h0, prox_conversion_count};
      OFS_WAIT_TIME: rd_mux = {24'h0, wait_time_count};
      OFS_CONFIG: rd_mux = {16'h0, prox_pulse_count, 4'h0, led_drive_strength,
        1'b0, long_wait_select};
      OFS_CTHR: rd_mux = {cthr_hi_reg, cthr_lo_reg};
      OFS_PTHR: rd_mux = {pthr_hi_reg, pthr_lo_reg};
      OFS_PERS: rd_mux = {24'h0, ppers_reg, cpers_reg};
      OFS_STATUS: rd_mux = {26'h0, pchk.flag, cchk.flag, 2'b00,
        prox_result_valid, color_valid_reg};
      OFS_CDATA0: rd_mux = {color_data_reg[0], color_data_reg[3]};
      OFS_CDATA1: rd_mux = {color_data_reg[2], color_data_reg[1]};
      OFS_PROX_DATA: rd_mux = {16'h0, prox_result_regs[15:8], prox_result_regs[7:0]};
      default:
      begin
        rd_mux = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
      pslverr <= psel && !penable && !rd_hit;
    end
  end

  // power-on bit at offset zero, bit zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_reg <= ENABLE_RST;
      color_integration_count <= TIME_RST;
      prox_conversion_count <= TIME_RST;
      wait_time_count <= TIME_RST;
      long_wait_select <= 1'b0;
      led_drive_strength <= DRIVE_RST;
      prox_pulse_count <= PROX_PULSE_COUNT_RST;
      cthr_lo_reg <= THR_LO_RST;
      cthr_hi_reg <= THR_HI_RST;
      pthr_lo_reg <= THR_LO_RST;
      pthr_hi_reg <= THR_HI_RST;
      cpers_reg <= 4'h0;
      ppers_reg <= 4'h0;
    end
    else if (wr_go && rd_hit)
    begin
      unique case (paddr)
        OFS_ENABLE: enable_reg <= pwdata[5:0];
        OFS_COLOR_TIME: color_integration_count <= pwdata[7:0];
        OFS_PROX_TIME: prox_conversion_count <= pwdata[7:0];
        OFS_WAIT_TIME: wait_time_count <= pwdata[7:0];
        OFS_CONFIG:
        begin
          long_wait_select <= pwdata[CFG_LONG];
          // 0 100 mA, 1 50 mA, 2 25 mA, 3 12.5 mA
          led_drive_strength <= pwdata[CFG_DRV_LO +: 2];
          prox_pulse_count <= pwdata[CFG_PULSES_LO +: 8];
        end
        OFS_CTHR: {cthr_hi_reg, cthr_lo_reg} <= pwdata;
        OFS_PTHR: {pthr_hi_reg, pthr_lo_reg} <= pwdata;
        OFS_PERS: {ppers_reg, cpers_reg} <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // helper counters for the checks below
  logic [7:0] led_run, led_since, pulse_seen;
  logic led_rose_once;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      led_run <= 8'h00;
      led_since <= 8'h00;
      pulse_seen <= 8'h00;
      led_rose_once <= 1'b0;
    end
    else
    begin
      led_run <= led_sink_output ? led_run + 8'h01 : 8'h00;
      led_since <= (led_sink_output && led_run == 8'h00) ? 8'h01 : led_since + 8'h01;
      led_rose_once <= state_reg == ST_PROX_ACCUM && (led_rose_once || led_sink_output);
      pulse_seen <= state_reg == ST_PROX_WAIT ? 8'h00
        : pulse_seen + 8'((led_sink_output && led_run == 8'h00) ? 1 : 0);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_sleep_stays: assert property (state_reg == ST_SLEEP && !power_on_bit
    |=> state_reg == ST_SLEEP && !led_sink_output)
    else $error("left sleep without power-on");
  a_start_on_power: assert property (state_reg == ST_SLEEP && power_on_bit
    |=> state_reg == ST_START)
    else $error("power-on did not reach start");
  a_conv_finish: assert property (state_reg == ST_PROX_WAIT && !power_on_bit
    |=> state_reg inside {ST_PROX_WAIT, ST_PROX_ADC})
    else $error("conversion cut short by power-off");
  a_led_width: assert property ($fell(led_sink_output) |-> led_run == 8'(LED_ON_CYC))
    else $error("led on-time wrong");
  a_led_period: assert property (led_sink_output && led_run == 8'h00 && led_rose_once
    |-> led_since == 8'(LED_PER_CYC))
    else $error("led period wrong");
  a_pulse_count: assert property (state_reg == ST_PROX_ACCUM && accum_done
    |-> pulse_seen == pulse_target)
    else $error("pulse count differs from setting");
  a_wait_fixed: assert property ($rose(state_reg == ST_PROX_WAIT)
    |-> steps_left_reg == 12'h000 && step_cnt_reg == '0)
    else $error("proximity wait not one step");
  a_color_move: assert property (state_reg == ST_COLOR_ADC && phase_done
    |=> color_data_reg[3] == $past(acc_plus[3]) && color_data_reg[0] == $past(acc_plus[0])
    && color_valid_reg)
    else $error("colour results not moved together");
  a_prox_valid: assert property (!proximity_enable && !(state_reg == ST_PROX_ADC && phase_done)
    |=> !prox_result_valid)
    else $error("proximity valid kept while disabled");
  a_int_level: assert property (!int_n && !cchk.flag && !pchk.flag |=> int_n)
    else $error("interrupt pin not following flags");

  c_prox_cycle: cover property (state_reg == ST_PROX_ADC && phase_done);
  c_color_cycle: cover property (state_reg == ST_COLOR_ADC && phase_done);
  c_long_wait: cover property (state_reg == ST_WAIT && long_wait_select);
  c_int_pin: cover property ($fell(int_n));
endmodule : cpm_sequencer

// ### test/cpm_front_model.sv
`timescale 1ns/1ps
module cpm_front_model #(
  parameter logic [9:0] AMBIENT = 10'h005,
  parameter logic [9:0] REFLECT = 10'h000
) (
  // led drive seen by the photodiodes
  input wire logic led_sink_output,
  // photodiode levels
  output logic [9:0] red_level,
  output logic [9:0] green_level,
  output logic [9:0] blue_level,
  output logic [9:0] clear_level,
  output logic [9:0] prox_level
);
  assign red_level = 10'h011;
  assign green_level = 10'h022;
  assign blue_level = 10'h033;
  assign clear_level = 10'h044;
  assign prox_level = AMBIENT + (led_sink_output ? REFLECT : 10'h000);
endmodule : cpm_front_model

// ### test/cpm_sequencer_tb.sv
`timescale 1ns/1ps
module cpm_sequencer_tb import cpm_pkg::*;;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, led_q = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, led, int_n, serr;
  logic [1:0] drv;
  logic [9:0] r, g, b, c, p;
  int err_count = 0, num_checks = 0, pulses = 0, wid = 0, last_w = 0, n;
  initial forever #50 pclk = ~pclk;
  cpm_sequencer #(.STEP_CYC(50), .LVL_W(10)) i_cpm_sequencer (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .red_level(r), .green_level(g),
    .blue_level(b), .clear_level(c), .prox_level(p), .led_sink_output(led),
    .led_drive_strength(drv), .int_n(int_n));
  cpm_front_model i_cpm_front_model (.led_sink_output(led), .red_level(r), .green_level(g),
    .blue_level(b), .clear_level(c), .prox_level(p));
  // pulse count and high width of the led output
  always @(posedge pclk)
  begin
    if (led && !led_q) pulses++;
    if (led) wid++;
    else if (led_q)
    begin
      last_w = wid;
      wid = 0;
    end
    led_q = led;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a wait for the answer
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic poll(input int bi);
    n = 0;
    do
    begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (q[bi] !== 1'b1 && n < 400);
    chk("status poll", q[bi], 32'h1);
  endtask : poll
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // hang guard, about five times the expected run
  initial
  begin
    #1_000_000;
    err_count++;
    print_verdict();
  end
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    chk("int_n idle", int_n, 32'h1);
    apb(1'b0, OFS_ENABLE, 32'h0); chk("enable", q, 32'h0);
    apb(1'b0, OFS_COLOR_TIME, 32'h0); chk("color time", q, 32'hff);
    apb(1'b0, OFS_PROX_TIME, 32'h0); chk("prox time", q, 32'hff);
    apb(1'b0, OFS_CONFIG, 32'h0); chk("config", q, 32'h100);
    apb(1'b0, OFS_CTHR, 32'h0); chk("cthr", q, 32'hffff0000);
    apb(1'b0, 8'h3c, 32'h0); chk("slverr", serr, 32'h1);
    repeat (100) @(posedge pclk);
    chk("sleep pulses", pulses, 32'h0);
    $display("test reset done");
    // three pulses, drive 2, long wait; low threshold 1 so a zero result is out of range
    apb(1'b1, OFS_CONFIG, 32'h0000_0309);
    // the drive output updates on the access edge, so look one edge later
    @(posedge pclk);
    chk("drive", drv, 32'h2);
    apb(1'b1, OFS_PTHR, 32'hffff_0001);
    // a wait phase between cycles keeps the pulse count still while the bench looks
    apb(1'b1, OFS_ENABLE, 32'h2d);
    poll(ST_PROX_VALID);
    chk("pulses", pulses, 32'h3);
    chk("led width", last_w, LED_ON_CYC);
    apb(1'b0, OFS_PROX_DATA, 32'h0); chk("prox data", q, 32'h0);
    repeat (3) @(posedge pclk);
    chk("int_n prox", int_n, 32'h0);
    // twelve wait steps of 50 cycles: a plain wait would have pulsed again by now
    repeat (300) @(posedge pclk);
    chk("long wait", pulses, 32'h3);
    apb(1'b1, OFS_ENABLE, 32'h21);
    repeat (700) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0); chk("prox valid off", q[1], 32'h0);
    chk("int_n held", int_n, 32'h0);
    apb(1'b1, OFS_STATUS, 32'h20);
    repeat (3) @(posedge pclk);
    chk("int_n cleared", int_n, 32'h1);
    $display("test proximity done");
    // two steps per colour cycle; persistence of two
    apb(1'b1, OFS_COLOR_TIME, 32'hfe);
    apb(1'b1, OFS_CTHR, 32'h0000_0100);
    apb(1'b1, OFS_PERS, 32'h2);
    apb(1'b1, OFS_ENABLE, 32'h13);
    poll(ST_CVALID);
    repeat (3) @(posedge pclk);
    chk("int_n first", int_n, 32'h1);
    apb(1'b0, OFS_CDATA0, 32'h0); chk("cdata0", q, 32'h0022_0088);
    apb(1'b0, OFS_CDATA1, 32'h0); chk("cdata1", q, 32'h0066_0044);
    repeat (200) @(posedge pclk);
    chk("int_n second", int_n, 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0); chk("flags", q[5:4], 32'h1);
    $display("test colour done");
    print_verdict();
  end
endmodule : cpm_sequencer_tb
